// ### rtl/dssd_pkg.sv
// constants, register map and helper for the drive status-signal detector
// assumes a 125 MHz clock and an Avalon-MM slave port with 32-bit data
// Overview of operation
// [R1] Relay polarity 0 closes the contact while its signal is on; polarity 1 inverts that.
// [R2] With polarity 1 the contact closes only after control voltage is up (about 1 s) and opens on any fault.
// [R3] Frequency arrival is on while output frequency is within the set width (0.0 to 10.0 Hz) of set frequency.
// [R4] Level detect A turns on when output frequency exceeds its level (0 to 400 Hz), hysteresis 0.0 to 30.0 Hz.
// [R5] Overload mode 0 uses a thermal model of output current, mode 1 compares output current directly.
// [R6] In current mode warning A comes only after current stays above its level for the delay (0.1 to 60.0 s).
// [R7] The overload delay applies only in current mode and is ignored in thermal mode; the code ignores it there for warning A only, warning B keeps it.
// [R8] Overload level A spans 5 to 200 % of rated current and warning A releases at 90 % of it.
// [R9] Level detect B compares output frequency against its own level of 0 to 400 Hz.
// [R10] Warning B compares output current with its own level of 5 to 200 % and releases at 90 % of it.
// [R11] Speed display is output frequency times coefficient A, settable from -999.00 to +999.00.
// [R12] For speed display the coefficient is clamped to the range 0.01 to 200.00.
// [R13] PID display is input times (A minus B) plus B.
// [R14] Displayed current, voltage, torque and power (items 3, 4, 8, 9) pass a 0.0 to 5.0 s filter.
// [R15] Level detect B releases using the hysteresis width of level detect A.
// [R16] Warning B asserts only after current exceeds its level for longer than the shared delay.
// [R17] Level detect A releases only when frequency falls below its level minus the hysteresis.
package dssd_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TICK_NS = 100_000_000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned ESTABLISH_MS = 1000;
   localparam int unsigned ESTABLISH_TICKS = (ESTABLISH_MS + TICK_MS - 1) / TICK_MS;
   // register indices, byte address is four times the index
   localparam int unsigned N_RW = 11;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_ARR_WIDTH = 4'h1;
   localparam logic [3:0] IDX_LEVEL_A = 4'h2;
   localparam logic [3:0] IDX_HYST = 4'h3;
   localparam logic [3:0] IDX_OL_LEVEL_A = 4'h4;
   localparam logic [3:0] IDX_OL_DELAY = 4'h5;
   localparam logic [3:0] IDX_LEVEL_B = 4'h6;
   localparam logic [3:0] IDX_OL_LEVEL_B = 4'h7;
   localparam logic [3:0] IDX_COEFF_MAX = 4'h8;
   localparam logic [3:0] IDX_COEFF_MIN = 4'h9;
   localparam logic [3:0] IDX_FILTER = 4'hA;
   localparam logic [3:0] IDX_STATUS = 4'hB;
   localparam logic [3:0] IDX_DISPLAY = 4'hC;
   localparam int unsigned CTRL_POL_BIT = 0;
   localparam int unsigned CTRL_MODE_BIT = 1;
   localparam int unsigned CTRL_ITEM_LSB = 8;
   localparam int unsigned ITEM_W = 4;
   localparam logic [31:0] RW_MASK [N_RW] = '{
      32'h0000_0F03, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
      32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_FFFF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00FF};
   localparam logic [31:0] RW_RESET [N_RW] = '{
      32'h0000_0000, 32'h0000_0019, 32'h0000_0258, 32'h0000_000A,
      32'h0000_03E8, 32'h0000_0064, 32'h0000_0258, 32'h0000_03E8,
      32'h0000_0064, 32'h0000_0000, 32'h0000_0005};
   // status word bits
   localparam int unsigned ST_ARRIVAL = 0;
   localparam int unsigned ST_LEVEL_A = 1;
   localparam int unsigned ST_LEVEL_B = 2;
   localparam int unsigned ST_OL_A = 3;
   localparam int unsigned ST_OL_B = 4;
   localparam int unsigned ST_RELAY = 5;
   localparam int unsigned ST_READY = 6;
   // display items
   localparam logic [3:0] ITEM_SET_FREQ = 4'h2;
   localparam logic [3:0] ITEM_CURRENT = 4'h3;
   localparam logic [3:0] ITEM_VOLTAGE = 4'h4;
   localparam logic [3:0] ITEM_SYNC = 4'h5;
   localparam logic [3:0] ITEM_LINE = 4'h6;
   localparam logic [3:0] ITEM_LOAD = 4'h7;
   localparam logic [3:0] ITEM_TORQUE = 4'h8;
   localparam logic [3:0] ITEM_POWER = 4'h9;
   localparam logic [3:0] ITEM_PID_1 = 4'hA;
   localparam logic [3:0] ITEM_PID_2 = 4'hB;
   localparam logic [3:0] ITEM_PID_FB = 4'hC;
   localparam logic signed [31:0] SPEED_COEFF_LO = 32'sh0000_0001;
   localparam logic signed [31:0] SPEED_COEFF_HI = 32'sh0000_4E20;
   localparam int unsigned PID_FRAC_BITS = 15;
   localparam int unsigned THERM_SHIFT = 3;
   localparam logic [19:0] REL_NUM = 20'h00009;
   localparam logic [19:0] REL_DEN = 20'h0000A;
   localparam logic [9:0] TIMER_SAT = 10'h3FF;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r & mask;
   endfunction : be_merge
endpackage : dssd_pkg

// ### rtl/dssd_filter.sv
// first-order display smoothing stage, one per filtered display item
// assumes tick pulses once per 100 ms and tc counts in 0.1 s units
`timescale 1ns/1ps
`default_nettype none
module dssd_filter (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic tick,
   input wire logic [7:0] tc,
   // data
   input wire logic [15:0] x,
   output logic [15:0] y_q
);
   logic signed [16:0] diff;
   logic signed [16:0] divisor;
   logic signed [16:0] step;
   logic signed [16:0] sum;
   logic [15:0] y_d;

   assign diff = $signed({1'b0, x}) - $signed({1'b0, y_q});
   assign divisor = $signed({9'h000, tc}) + 17'sh00001;
   // step never overshoots, so the sum stays inside 16 bits
   assign step = diff / divisor;
   assign sum = $signed({1'b0, y_q}) + step;
   assign y_d = (tc == 8'h00) ? x : (tick ? sum[15:0] : y_q);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         y_q <= 16'h0000;
      end else begin
         y_q <= y_d; // [R14]
      end
   end
endmodule : dssd_filter
`default_nettype wire

// ### rtl/dssd_top.sv
// status-signal detection, relay drive and display scaling of a motor drive
// assumes measurements arrive from logic on clk; fault_n is an asynchronous pin
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dssd_top #(
   parameter int unsigned TICK_CYCLES = dssd_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register bus
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // drive measurements, 0.1 Hz and 0.1 % units
   input wire logic [15:0] output_freq,
   input wire logic [15:0] set_freq,
   input wire logic [15:0] output_current,
   input wire logic [15:0] output_voltage,
   input wire logic [15:0] calc_torque,
   input wire logic [15:0] output_power,
   input wire logic [15:0] pid_value,
   // relay request and fault pin
   input wire logic relay_signal,
   input wire logic fault_n,
   // status outputs
   output logic freq_arrival_signal,
   output logic freq_level_detect_a,
   output logic freq_level_detect_b,
   output logic overload_warning_a,
   output logic overload_warning_b,
   output logic relay_contact_a,
   output logic [31:0] display_value
);
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
   localparam logic [3:0] EST_LAST = 4'(dssd_pkg::ESTABLISH_TICKS);

   // timebase and power-up
   logic [31:0] tick_cnt_q;
   logic tick;
   logic [3:0] est_q;
   logic ready_q;
   logic fault_s1_q;
   logic fault_s2_q;
   logic fault;

   assign tick = (tick_cnt_q == TICK_LAST);
   assign fault = ~fault_s2_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      end
   end

   // control voltage counted as up one second after reset release
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         est_q <= 4'h0;
         ready_q <= 1'b0;
      end else if (tick && !ready_q) begin
         est_q <= est_q + 4'h1;
         ready_q <= (est_q + 4'h1) >= EST_LAST; // [R2]
      end
   end

   // reset value reads as fault so the relay starts open
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fault_s1_q <= 1'b0;
         fault_s2_q <= 1'b0;
      end else begin
         fault_s1_q <= fault_n;
         fault_s2_q <= fault_s1_q;
      end
   end

   // register bus: one wait cycle, commit on the edge that sees waitrequest low
   logic wait_q;
   logic wait_d;
   logic bus_req;
   logic bus_commit;
   logic [3:0] word;
   logic [31:0] cfg_q [dssd_pkg::N_RW];
   logic [31:0] status_w;
   logic [31:0] rd_mux;
   logic [31:0] rdata_q;

   assign bus_req = avs_read | avs_write;
   assign bus_commit = bus_req & ~wait_q;
   assign wait_d = ~(bus_req & wait_q);
   assign word = avs_address[5:2];
   assign rd_mux = (word < 4'(dssd_pkg::N_RW)) ? cfg_q[word] :
                   (word == dssd_pkg::IDX_STATUS) ? status_w :
                   (word == dssd_pkg::IDX_DISPLAY) ? display_value : 32'h0000_0000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= wait_d;
         if (avs_read && wait_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < dssd_pkg::N_RW; gi++) begin : g_cfg
         logic wr_hit;
         assign wr_hit = bus_commit & avs_write & (word == 4'(gi));
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               cfg_q[gi] <= dssd_pkg::RW_RESET[gi];
            end else if (wr_hit) begin
               cfg_q[gi] <= dssd_pkg::be_merge(cfg_q[gi], avs_writedata, avs_byteenable,
                                               dssd_pkg::RW_MASK[gi]);
            end
         end
      end
   endgenerate

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   // configuration fields
   logic pol;
   logic mode;
   logic [3:0] item;
   logic [15:0] arr_width;
   logic [15:0] lvl_a;
   logic [15:0] hyst;
   logic [15:0] ol_lvl_a;
   logic [15:0] ol_lvl_b;
   logic [9:0] ol_delay;
   logic [15:0] lvl_b;
   logic signed [31:0] coeff_max;
   logic signed [31:0] coeff_min;
   logic [7:0] filt_tc;

   assign pol = cfg_q[dssd_pkg::IDX_CTRL][dssd_pkg::CTRL_POL_BIT];
   assign mode = cfg_q[dssd_pkg::IDX_CTRL][dssd_pkg::CTRL_MODE_BIT];
   assign item = cfg_q[dssd_pkg::IDX_CTRL][dssd_pkg::CTRL_ITEM_LSB +: dssd_pkg::ITEM_W];
   assign arr_width = cfg_q[dssd_pkg::IDX_ARR_WIDTH][15:0];
   assign lvl_a = cfg_q[dssd_pkg::IDX_LEVEL_A][15:0];
   assign hyst = cfg_q[dssd_pkg::IDX_HYST][15:0];
   assign ol_lvl_a = cfg_q[dssd_pkg::IDX_OL_LEVEL_A][15:0];
   assign ol_delay = cfg_q[dssd_pkg::IDX_OL_DELAY][9:0];
   assign lvl_b = cfg_q[dssd_pkg::IDX_LEVEL_B][15:0];
   assign ol_lvl_b = cfg_q[dssd_pkg::IDX_OL_LEVEL_B][15:0];
   assign coeff_max = $signed(cfg_q[dssd_pkg::IDX_COEFF_MAX]);
   assign coeff_min = $signed(cfg_q[dssd_pkg::IDX_COEFF_MIN]);
   assign filt_tc = cfg_q[dssd_pkg::IDX_FILTER][7:0];

   // frequency detectors
   logic [16:0] f_diff;
   logic arr_d;
   logic above_a;
   logic below_a;
   logic above_b;
   logic below_b;
   logic det_a_d;
   logic det_b_d;
   logic arr_q;
   logic det_a_q;
   logic det_b_q;

   assign f_diff = (output_freq >= set_freq) ? {1'b0, output_freq} - {1'b0, set_freq}
                                             : {1'b0, set_freq} - {1'b0, output_freq};
   assign arr_d = f_diff <= {1'b0, arr_width}; // [R3]
   assign above_a = output_freq > lvl_a; // [R4]
   // adding instead of subtracting keeps a small level from wrapping
   assign below_a = ({1'b0, output_freq} + {1'b0, hyst}) < {1'b0, lvl_a}; // [R17]
   assign above_b = output_freq > lvl_b; // [R9]
   assign below_b = ({1'b0, output_freq} + {1'b0, hyst}) < {1'b0, lvl_b}; // [R15]
   assign det_a_d = above_a | (det_a_q & ~below_a);
   assign det_b_d = above_b | (det_b_q & ~below_b);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         arr_q <= 1'b0;
         det_a_q <= 1'b0;
         det_b_q <= 1'b0;
      end else begin
         arr_q <= arr_d;
         det_a_q <= det_a_d;
         det_b_q <= det_b_d;
      end
   end

   // overload warnings
   logic [15:0] therm_q;
   logic signed [16:0] therm_diff;
   logic signed [16:0] therm_sum;
   logic [15:0] qty_a;
   logic [19:0] qty_a_x10;
   logic [19:0] cur_x10;
   logic ol_above_a;
   logic ol_rel_a;
   logic ol_above_b;
   logic ol_rel_b;
   logic cur_above_a;
   logic [9:0] cnt_a_q;
   logic [9:0] cnt_b_q;
   logic done_a;
   logic done_b;
   logic ol_a_d;
   logic ol_b_d;
   logic ol_a_q;
   logic ol_b_q;

   // coarse first-order heating estimate, slower than the current itself
   assign therm_diff = $signed({1'b0, output_current}) - $signed({1'b0, therm_q});
   assign therm_sum = $signed({1'b0, therm_q}) + (therm_diff >>> dssd_pkg::THERM_SHIFT);
   assign qty_a = mode ? output_current : therm_q; // [R5]
   assign qty_a_x10 = {4'h0, qty_a} * dssd_pkg::REL_DEN;
   assign cur_x10 = {4'h0, output_current} * dssd_pkg::REL_DEN;
   assign ol_above_a = qty_a > ol_lvl_a;
   assign ol_rel_a = qty_a_x10 <= ({4'h0, ol_lvl_a} * dssd_pkg::REL_NUM); // [R8]
   assign cur_above_a = output_current > ol_lvl_a;
   assign ol_above_b = output_current > ol_lvl_b;
   assign ol_rel_b = cur_x10 <= ({4'h0, ol_lvl_b} * dssd_pkg::REL_NUM); // [R10]
   assign done_a = cnt_a_q >= ol_delay;
   assign done_b = cnt_b_q >= ol_delay;
   // timer gates warning A only in the current mode, warning B in both modes
   assign ol_a_d = (ol_above_a & (done_a | ~mode)) | (ol_a_q & ~ol_rel_a); // [R6] [R7]
   assign ol_b_d = (ol_above_b & done_b) | (ol_b_q & ~ol_rel_b); // [R16]

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         therm_q <= 16'h0000;
      end else if (tick) begin
         therm_q <= therm_sum[15:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_a_q <= 10'h000;
         cnt_b_q <= 10'h000;
      end else begin
         if (!cur_above_a) begin
            cnt_a_q <= 10'h000;
         end else if (tick && cnt_a_q != dssd_pkg::TIMER_SAT) begin
            cnt_a_q <= cnt_a_q + 10'h001; // [R6]
         end
         if (!ol_above_b) begin
            cnt_b_q <= 10'h000;
         end else if (tick && cnt_b_q != dssd_pkg::TIMER_SAT) begin
            cnt_b_q <= cnt_b_q + 10'h001; // [R16]
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ol_a_q <= 1'b0;
         ol_b_q <= 1'b0;
      end else begin
         ol_a_q <= ol_a_d;
         ol_b_q <= ol_b_d;
      end
   end

   // relay contact
   logic relay_d;
   logic relay_q;

   assign relay_d = pol ? (ready_q & ~fault & ~relay_signal) : relay_signal; // [R1] [R2]

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         relay_q <= 1'b0;
      end else begin
         relay_q <= relay_d;
      end
   end

   // display scaling
   logic [15:0] filt_in [4];
   logic [15:0] filt_out [4];
   logic signed [31:0] coeff_eff;
   logic signed [48:0] speed_prod;
   logic signed [31:0] coeff_span;
   logic signed [48:0] pid_prod;
   logic signed [31:0] pid_disp;
   logic [31:0] disp_d;
   logic [31:0] disp_q;

   assign filt_in[0] = output_current;
   assign filt_in[1] = output_voltage;
   assign filt_in[2] = calc_torque;
   assign filt_in[3] = output_power;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         dssd_filter u_filt (
            .clk(clk),
            .reset_n(reset_n),
            .tick(tick),
            .tc(filt_tc),
            .x(filt_in[gi]),
            .y_q(filt_out[gi])
         );
      end
   endgenerate

   assign coeff_eff = (coeff_max < dssd_pkg::SPEED_COEFF_LO) ? dssd_pkg::SPEED_COEFF_LO :
                      (coeff_max > dssd_pkg::SPEED_COEFF_HI) ? dssd_pkg::SPEED_COEFF_HI
                                                             : coeff_max; // [R12]
   assign speed_prod = $signed({1'b0, output_freq}) * coeff_eff; // [R11]
   assign coeff_span = coeff_max - coeff_min;
   assign pid_prod = $signed({1'b0, pid_value}) * coeff_span;
   assign pid_disp = 32'(pid_prod >>> dssd_pkg::PID_FRAC_BITS) + coeff_min; // [R13]
   assign disp_d = (item == dssd_pkg::ITEM_SET_FREQ) ? {16'h0000, set_freq} :
                   (item == dssd_pkg::ITEM_CURRENT) ? {16'h0000, filt_out[0]} : // [R14]
                   (item == dssd_pkg::ITEM_VOLTAGE) ? {16'h0000, filt_out[1]} :
                   (item == dssd_pkg::ITEM_SYNC) ? {16'h0000, output_freq} :
                   (item == dssd_pkg::ITEM_LINE) ? 32'(speed_prod) :
                   (item == dssd_pkg::ITEM_LOAD) ? 32'(speed_prod) :
                   (item == dssd_pkg::ITEM_TORQUE) ? {16'h0000, filt_out[2]} :
                   (item == dssd_pkg::ITEM_POWER) ? {16'h0000, filt_out[3]} :
                   (item == dssd_pkg::ITEM_PID_1) ? pid_disp :
                   (item == dssd_pkg::ITEM_PID_2) ? pid_disp :
                   (item == dssd_pkg::ITEM_PID_FB) ? pid_disp :
                   (item < dssd_pkg::ITEM_SET_FREQ) ? {16'h0000, output_freq} : 32'h0000_0000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         disp_q <= 32'h0000_0000;
      end else begin
         disp_q <= disp_d;
      end
   end

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[dssd_pkg::ST_ARRIVAL] = arr_q;
      status_w[dssd_pkg::ST_LEVEL_A] = det_a_q;
      status_w[dssd_pkg::ST_LEVEL_B] = det_b_q;
      status_w[dssd_pkg::ST_OL_A] = ol_a_q;
      status_w[dssd_pkg::ST_OL_B] = ol_b_q;
      status_w[dssd_pkg::ST_RELAY] = relay_q;
      status_w[dssd_pkg::ST_READY] = ready_q;
   end

   assign freq_arrival_signal = arr_q;
   assign freq_level_detect_a = det_a_q;
   assign freq_level_detect_b = det_b_q;
   assign overload_warning_a = ol_a_q;
   assign overload_warning_b = ol_b_q;
   assign relay_contact_a = relay_q;
   assign display_value = disp_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_fault_seen;
      fault && pol;
   endsequence

   a_relay_failsafe: assert property (s_fault_seen |=> !relay_contact_a) // [R2]
      else $error("relay closed under fault");
   a_relay_not_ready: assert property (pol && !ready_q |=> !relay_contact_a) // [R2]
      else $error("relay closed before ready");
   a_relay_direct: assert property (!pol |=> relay_contact_a == $past(relay_signal)) // [R1]
      else $error("relay does not follow signal");
   a_arrival_width: assert property (f_diff > {1'b0, arr_width} |=> !freq_arrival_signal) // [R3]
      else $error("arrival on outside width");
   a_level_a_set: assert property (above_a |=> freq_level_detect_a) // [R4]
      else $error("level a missed");
   a_level_a_hold: assert property (freq_level_detect_a && !below_a |=> freq_level_detect_a) // [R17]
      else $error("level a released early");
   a_level_b_rel: assert property (below_b && !above_b |=> !freq_level_detect_b) // [R15]
      else $error("level b not released");
   a_ol_a_delay: assert property (mode && $rose(overload_warning_a) |-> $past(done_a)) // [R6]
      else $error("warning a before delay");
   a_ol_a_thermal: assert property (!mode && ol_above_a |=> overload_warning_a) // [R7]
      else $error("thermal warning delayed");
   a_ol_a_release: assert property (ol_rel_a && !ol_above_a |=> !overload_warning_a) // [R8]
      else $error("warning a not released");
   a_ol_b_delay: assert property ($rose(overload_warning_b) |-> $past(done_b && ol_above_b)) // [R16]
      else $error("warning b before delay");
   a_ol_b_release: assert property (ol_rel_b |=> !overload_warning_b) // [R10]
      else $error("warning b not released");
   a_speed_clamp: assert property (item == dssd_pkg::ITEM_LOAD && coeff_max > dssd_pkg::SPEED_COEFF_HI |=> // [R12]
      display_value == 32'($past(output_freq)) * 32'(dssd_pkg::SPEED_COEFF_HI))
      else $error("speed coefficient not clamped");
endmodule : dssd_top
`default_nettype wire

// ### sim/dssd_top_test.sv
// self-checking bench for dssd_top: registers, relay, detectors, overload and display
// assumes a tick shortened to TCK cycles so the control-voltage wait stays brief
`timescale 1ns/1ps
`default_nettype none
module dssd_top_test;
   localparam int TCK = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [5:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, display_value;
   logic [3:0] avs_byteenable;
   logic [15:0] output_freq, set_freq, output_current, output_voltage, calc_torque, output_power, pid_value;
   logic relay_signal, fault_n;
   logic freq_arrival_signal, freq_level_detect_a, freq_level_detect_b;
   logic overload_warning_a, overload_warning_b, relay_contact_a;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] rs = 32'h0000_0050;
   dssd_top #(.TICK_CYCLES(TCK)) i_dssd_top (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .output_freq(output_freq), .set_freq(set_freq), .output_current(output_current),
      .output_voltage(output_voltage), .calc_torque(calc_torque), .output_power(output_power),
      .pid_value(pid_value), .relay_signal(relay_signal), .fault_n(fault_n),
      .freq_arrival_signal(freq_arrival_signal), .freq_level_detect_a(freq_level_detect_a),
      .freq_level_detect_b(freq_level_detect_b), .overload_warning_a(overload_warning_a),
      .overload_warning_b(overload_warning_b), .relay_contact_a(relay_contact_a),
      .display_value(display_value));
   always #4 clk = ~clk;
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   // hang guard, far above the fewer than a thousand cycles the sequence needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail = n_fail + 1;
         finish_test();
      end
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd
   function automatic logic lvl(input logic prev, input int f, input int lv, input int h);
      if (f > lv) return 1'b1;
      if (f + h < lv) return 1'b0;
      return prev;
   endfunction : lvl
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   // holds the request until waitrequest is sampled low; only the hang guard ends a stuck wait
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      avs_byteenable <= 4'hF;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic show(input logic [3:0] item, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b1, dssd_pkg::IDX_CTRL, {20'h0, item, 8'h00}, q);
      step(TCK + 3);
      check("display", display_value, exp);
   endtask : show
   initial begin
      logic [31:0] q;
      logic ea, eb;
      int f, s, d;
      int fl [10] = '{600, 601, 595, 589, 600, 700, 701, 695, 689, 500};
      {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
      {output_freq, set_freq, output_current, pid_value, relay_signal} = '0;
      {output_voltage, calc_torque, output_power} = {rnd(), 16'hABCD};
      fault_n = 1'b1;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b1, dssd_pkg::IDX_CTRL, 32'h1, q);
      step(3);
      check("relay early", relay_contact_a, 0);
      step(12 * TCK);
      check("relay ready", relay_contact_a, 1);
      relay_signal <= 1'b1;
      step(3);
      check("relay inverted", relay_contact_a, 0);
      relay_signal <= 1'b0;
      fault_n <= 1'b0;
      step(5);
      check("relay fault", relay_contact_a, 0);
      fault_n <= 1'b1;
      step(5);
      check("relay back", relay_contact_a, 1);
      bus(1'b1, dssd_pkg::IDX_CTRL, 32'h0, q);
      relay_signal <= 1'b1;
      step(3);
      check("relay direct", relay_contact_a, 1);
      $display("relay test done");
      for (int i = 1; i < dssd_pkg::N_RW; i++) begin
         bus(1'b0, 4'(i), 32'h0, q);
         check("reset value", q, dssd_pkg::RW_RESET[i]);
      end
      bus(1'b1, 4'hD, 32'hFFFF_FFFF, q);
      bus(1'b0, 4'hD, 32'h0, q);
      check("unmapped", q, 32'h0);
      $display("register test done");
      for (int i = 0; i < 24; i++) begin
         f = 500 + int'(rnd() % 60);
         s = 500 + int'(rnd() % 60);
         output_freq <= 16'(f);
         set_freq <= 16'(s);
         step(3);
         d = f > s ? f - s : s - f;
         if (d != 25) check("arrival", freq_arrival_signal, d < 25);
      end
      $display("arrival test done");
      bus(1'b1, dssd_pkg::IDX_LEVEL_B, 32'd700, q);
      ea = 1'b0;
      eb = 1'b0;
      foreach (fl[i]) begin
         output_freq <= 16'(fl[i]);
         step(3);
         ea = lvl(ea, fl[i], 600, 10);
         eb = lvl(eb, fl[i], 700, 10);
         check("level a", freq_level_detect_a, ea);
         check("level b", freq_level_detect_b, eb);
      end
      $display("level test done");
      bus(1'b1, dssd_pkg::IDX_OL_DELAY, 32'd1000, q);
      output_current <= 16'd1100;
      step(3 * TCK);
      check("thermal slow", overload_warning_a, 0);
      for (int i = 0; i < 80 && overload_warning_a !== 1'b1; i++) step(TCK);
      check("thermal warn", overload_warning_a, 1);
      output_current <= 16'd0;
      bus(1'b1, dssd_pkg::IDX_OL_DELAY, 32'd3, q);
      bus(1'b1, dssd_pkg::IDX_OL_LEVEL_B, 32'd1200, q);
      bus(1'b1, dssd_pkg::IDX_CTRL, 32'h2, q);
      step(3);
      check("current idle", overload_warning_a, 0);
      output_current <= 16'd1250;
      step(2 * TCK);
      check("delay a", overload_warning_a, 0);
      check("delay b", overload_warning_b, 0);
      step(3 * TCK);
      check("warn a", overload_warning_a, 1);
      check("warn b", overload_warning_b, 1);
      output_current <= 16'd1081;
      step(3);
      check("hold b", overload_warning_b, 1);
      output_current <= 16'd1080;
      step(3);
      check("release b", overload_warning_b, 0);
      check("hold a", overload_warning_a, 1);
      output_current <= 16'd900;
      step(3);
      check("release a", overload_warning_a, 0);
      $display("overload test done");
      bus(1'b1, dssd_pkg::IDX_FILTER, 32'h0, q);
      output_freq <= 16'd500;
      show(4'h3, 32'(output_current));
      show(4'h4, 32'(output_voltage));
      show(4'h8, 32'(calc_torque));
      show(4'h9, 32'(output_power));
      bus(1'b1, dssd_pkg::IDX_COEFF_MAX, 32'd30000, q);
      show(4'h7, 32'd500 * 32'd20000);
      bus(1'b1, dssd_pkg::IDX_COEFF_MAX, 32'hFFFF_FFFB, q);
      show(4'h6, 32'd500);
      bus(1'b1, dssd_pkg::IDX_COEFF_MAX, 32'd250, q);
      show(4'h6, 32'd500 * 32'd250);
      bus(1'b1, dssd_pkg::IDX_COEFF_MAX, 32'd1000, q);
      bus(1'b1, dssd_pkg::IDX_COEFF_MIN, 32'd200, q);
      pid_value <= 16'h4000;
      for (int i = 10; i < 13; i++) show(4'(i), 32'd600);
      bus(1'b1, dssd_pkg::IDX_FILTER, 32'd5, q);
      show(4'h2, 32'(set_freq));
      show(4'h5, 32'd500);
      show(4'h4, 32'(output_voltage));
      output_voltage <= 16'h0000;
      step(3);
      check("filter slow", display_value == 32'h0, 0);
      $display("display test done");
      finish_test();
   end
endmodule : dssd_top_test
`default_nettype wire
